// >>> inc/llf_pkg.sv
// Constants and types for the LED line fault flag registers.
//****************************************************************
// Summary of operation
//****************************************************************
// Summary of operation
// [RULE1] Read-only open-load register, 48 bits: bit n warns for line n.
// [RULE2] A line status bit reads one while that line has a detected warning.
// [RULE3] A line status bit reads zero while that line has no warning.
// [RULE4] Short warnings of lines 48 to 63 sit in bits 15:0, bit 0 is line 48.
// [RULE5] Bit 15 of the upper short register carries the warning of line 63.
// [RULE6] Both status registers are read through the serial data output pin.
// [RULE7] Writes have no effect; reserved bits always read back as zero.
package llf_pkg;

    //************************************************************
    // Widths and field positions.
    //************************************************************
    localparam int unsigned REG_WIDTH        = 48;
    localparam int unsigned OPEN_LINES       = 48;
    localparam int unsigned SHORT_LINES      = 16;
    localparam int unsigned SHORT_FIRST_LINE = 48;
    localparam int unsigned SHORT_FIELD_LSB  = 0;

    //************************************************************
    // Register selectors, reset values and shift count.
    //************************************************************
    localparam logic       SEL_OPEN_LOAD   = 1'h0;
    localparam logic       SEL_SHORT_HIGH  = 1'h1;
    localparam logic [47:0] OPEN_RESET     = 48'h0;
    localparam logic [15:0] SHORT_RESET    = 16'h0;
    localparam logic [5:0]  SHIFT_LAST     = 6'h2F;

    typedef enum logic {
        LLF_IDLE,
        LLF_SHIFT
    } llf_state_type;

endpackage

// >>> inc/llf_shift_if.sv
// Interface between the register selector and the serial shifter.
`timescale 1ns/10ps
interface llf_shift_if;
    logic        load;
    logic [47:0] word;
    logic        active;
    logic        last;
    logic        bit_out;

    modport ctrl (
        output load,
        output word,
        input  active,
        input  last,
        input  bit_out
    );

    modport shifter (
        input  load,
        input  word,
        output active,
        output last,
        output bit_out
    );
endinterface

// >>> verilog/llf_shifter.sv
// Serial shifter that sends a 48-bit word out most significant bit first.
`timescale 1ns/10ps
module llf_shifter (
    input wire logic   clk,
    input wire logic   rst,
    input wire logic   clk_en,
    llf_shift_if.shifter sh
);
    logic [47:0] word_q;
    logic [47:0] word_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic        act_q;
    logic        act_d;
    logic        at_last;

    //************************************************************
    // Shift control.
    //************************************************************
    assign at_last = act_q && (cnt_q == 6'h00);
    assign word_d  = sh.load ? sh.word : {word_q[46:0], 1'b0};
    assign cnt_d   = sh.load ? llf_pkg::SHIFT_LAST : cnt_q - 6'h01;
    assign act_d   = sh.load | (act_q & ~at_last);

    always_ff @(posedge clk) begin
        if (rst) begin
            word_q <= llf_pkg::OPEN_RESET;
            cnt_q  <= 6'h00;
            act_q  <= 1'b0;
        end else if (clk_en) begin
            word_q <= word_d;
            cnt_q  <= cnt_d;
            act_q  <= act_d;
        end
    end

    assign sh.active  = act_q;
    assign sh.last    = at_last;
    assign sh.bit_out = word_q[47];

    //************************************************************
    // Checks.
    //************************************************************
    property run_48;
        @(posedge clk) disable iff (rst || !clk_en)
        sh.load |=> act_q ##47 at_last ##1 !act_q;
    endproperty

    shift_len_a: assert property (run_48) // [RULE6]
        else $error("Shifter did not run for exactly 48 bits.");
endmodule

// >>> verilog/llf_top.sv
// LED line fault flag registers read out over the serial data output.
`timescale 1ns/10ps
module llf_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [47:0] open_load_line_flags_in,
    input  wire logic [15:0] short_line_flags_in,
    input  wire logic        read_req,
    input  wire logic        read_sel,
    output logic             read_ready,
    output logic             serial_data_out,
    output logic             serial_out_valid
);
    llf_pkg::llf_state_type state_q;
    llf_pkg::llf_state_type state_d;
    logic [47:0] open_load_line_flags_low_q;
    logic [15:0] short_line_flags_q;
    logic [47:0] short_line_flags_high;
    logic [47:0] sel_word;
    logic        accept;

    llf_shift_if sh_bus ();

    default clocking chk_cb @(posedge clk);
    endclocking

    default disable iff (rst || !clk_en);

    //************************************************************
    // Status capture.
    //************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            open_load_line_flags_low_q <= llf_pkg::OPEN_RESET;
            short_line_flags_q         <= llf_pkg::SHORT_RESET;
        end else if (clk_en) begin
            open_load_line_flags_low_q <= open_load_line_flags_in; // [RULE1]
            short_line_flags_q         <= short_line_flags_in; // [RULE4]
        end
    end

    // Line 48 lands on bit 0 and line 63 on bit 15.
    assign short_line_flags_high = {32'h0, short_line_flags_q}; // [RULE7]

    //************************************************************
    // Register select and read sequencing.
    //************************************************************
    assign read_ready = (state_q == llf_pkg::LLF_IDLE);
    assign accept     = read_req & read_ready;
    assign sel_word   = (read_sel == llf_pkg::SEL_SHORT_HIGH) ?
                        short_line_flags_high :
                        open_load_line_flags_low_q; // [RULE5]

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            llf_pkg::LLF_IDLE: begin
                if (accept) begin
                    state_d = llf_pkg::LLF_SHIFT;
                end
            end
            llf_pkg::LLF_SHIFT: begin
                if (sh_bus.last) begin
                    state_d = llf_pkg::LLF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= llf_pkg::LLF_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign sh_bus.load = accept;
    assign sh_bus.word = sel_word;

    llf_shifter u_shifter (
        .clk    (clk),
        .rst    (rst),
        .clk_en (clk_en),
        .sh     (sh_bus.shifter)
    );

    assign serial_data_out  = sh_bus.bit_out; // [RULE6]
    assign serial_out_valid = sh_bus.active;

    //************************************************************
    // Checks.
    //************************************************************
    sequence take_open;
        accept && (read_sel == llf_pkg::SEL_OPEN_LOAD);
    endsequence

    sequence take_short;
        accept && (read_sel == llf_pkg::SEL_SHORT_HIGH);
    endsequence

    sequence valid_8;
        serial_out_valid [*8];
    endsequence

    sequence frame_48;
        valid_8 ##1 valid_8 ##1 valid_8 ##1 valid_8 ##1 valid_8 ##1 valid_8
        ##1 !serial_out_valid;
    endsequence

    sequence quiet_8;
        (!serial_data_out) [*8];
    endsequence

    sequence reserved_32;
        quiet_8 ##1 quiet_8 ##1 quiet_8 ##1 quiet_8;
    endsequence

    property open_first_bit;
        take_open |=> serial_out_valid &&
            (serial_data_out == $past(open_load_line_flags_low_q[47]));
    endproperty

    open_msb_a: assert property (open_first_bit) // [RULE1]
        else $error("Open-load bit 47 not sent first.");

    property open_last_bit;
        take_open |-> ##48
            serial_data_out == $past(open_load_line_flags_low_q[0], 48);
    endproperty

    open_lsb_a: assert property (open_last_bit) // [RULE1]
        else $error("Open-load bit 0 not sent last.");

    property warn_reads_one;
        (open_load_line_flags_in[5] && short_line_flags_in[3]) |=>
            open_load_line_flags_low_q[5] && short_line_flags_q[3];
    endproperty

    flag_set_a: assert property (warn_reads_one) // [RULE2]
        else $error("Detected warning did not read as one.");

    property clear_reads_zero;
        (open_load_line_flags_in == 48'h0) &&
        (short_line_flags_in == 16'h0) |=>
            (open_load_line_flags_low_q == 48'h0) &&
            (short_line_flags_high == 48'h0);
    endproperty

    flag_clear_a: assert property (clear_reads_zero) // [RULE3]
        else $error("Absent warning did not read as zero.");

    property open_follows;
        clk_en |=> open_load_line_flags_low_q ==
            $past(open_load_line_flags_in);
    endproperty

    open_follow_a: assert property (open_follows) // [RULE2]
        else $error("Open-load flags did not follow their inputs.");

    property short_follows;
        clk_en |=> short_line_flags_q == $past(short_line_flags_in);
    endproperty

    short_follow_a: assert property (short_follows) // [RULE4]
        else $error("Short flags did not follow their inputs.");

    property short_bit0_last;
        take_short |-> ##48
            serial_data_out == $past(short_line_flags_q[0], 48);
    endproperty

    short_line48_a: assert property (short_bit0_last) // [RULE4]
        else $error("Line 48 not on bit 0.");

    property short_bit15_mid;
        take_short |-> ##33
            serial_data_out == $past(short_line_flags_q[15], 33);
    endproperty

    short_line63_a: assert property (short_bit15_mid) // [RULE5]
        else $error("Line 63 not on bit 15.");

    property reserved_low;
        take_short |=> reserved_32;
    endproperty

    reserved_zero_a: assert property (reserved_low) // [RULE7]
        else $error("Reserved bit read as one.");

    property read_frame;
        accept |=> frame_48;
    endproperty

    read_frame_a: assert property (read_frame) // [RULE6]
        else $error("Serial read frame not 48 bits.");

    property busy_refuse;
        serial_out_valid && !sh_bus.last |=>
            !read_ready && serial_out_valid;
    endproperty

    busy_refuse_a: assert property (busy_refuse) // [RULE6]
        else $error("Read accepted during a frame.");

    property idle_quiet;
        !serial_out_valid |-> !serial_data_out;
    endproperty

    idle_quiet_a: assert property (idle_quiet) // [RULE6]
        else $error("Serial data not low outside a frame.");

    property ready_when_idle;
        read_ready != serial_out_valid;
    endproperty

    ready_idle_a: assert property (ready_when_idle) // [RULE6]
        else $error("Ready and valid disagree.");

    property reset_clears;
        disable iff (1'b0)
        rst |=> read_ready && !serial_out_valid && !serial_data_out &&
            (open_load_line_flags_low_q == llf_pkg::OPEN_RESET) &&
            (short_line_flags_q == llf_pkg::SHORT_RESET);
    endproperty

    reset_clear_a: assert property (reset_clears) // [RULE3]
        else $error("Reset did not clear the flags and the frame.");

    property frozen_hold;
        disable iff (rst)
        !clk_en |=> $stable(open_load_line_flags_low_q) &&
            $stable(short_line_flags_q) && $stable(state_q);
    endproperty

    frozen_hold_a: assert property (frozen_hold) // [RULE1]
        else $error("State changed while the clock enable was low.");
endmodule

// >>> testbench/llf_host_model.sv
// Host controller model that requests a status read and collects the word.
`timescale 1ns/10ps
module llf_host_model (
    input  wire logic clk,
    input  wire logic read_ready,
    input  wire logic serial_data_out,
    input  wire logic serial_out_valid,
    output logic      read_req,
    output logic      read_sel
);
    initial begin
        read_req = 1'h0;
        read_sel = 1'h0;
    end

    // Holds the request until it is taken, then shifts bits in MSB first.
    task automatic read_word(input logic sel, input int gap,
                             output logic [47:0] w, output int n);
        repeat (gap + 1) @(posedge clk);
        read_req <= 1'h1;
        read_sel <= sel;
        do @(negedge clk); while (read_ready !== 1'h1);
        @(posedge clk);
        read_req <= 1'h0;
        w = 48'h0;
        n = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            if (serial_out_valid === 1'h1) begin
                w = {w[46:0], serial_data_out};
                n++;
            end else if (n > 0) begin
                break;
            end
        end
    endtask
endmodule

// >>> testbench/led_line_fault_flags_tb_top.sv
// Self-checking testbench for the LED line fault flag registers.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module led_line_fault_flags_tb_top;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        clk_en = 1'h1;
    logic [47:0] open_flags = 48'h0;
    logic [15:0] short_flags = 16'h0;
    logic        read_req;
    logic        read_sel;
    logic        read_ready;
    logic        sdo;
    logic        sov;
    logic [47:0] w;
    int          n;
    int          bad_count = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;

    llf_top llf_top_inst (.clk(clk), .rst(rst), .clk_en(clk_en),
        .open_load_line_flags_in(open_flags),
        .short_line_flags_in(short_flags), .read_req(read_req),
        .read_sel(read_sel), .read_ready(read_ready),
        .serial_data_out(sdo), .serial_out_valid(sov));

    llf_host_model llf_host_model_inst (.clk(clk), .read_ready(read_ready),
        .serial_data_out(sdo), .serial_out_valid(sov),
        .read_req(read_req), .read_sel(read_sel));

    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic test_reset();
        `CHK("ready_in_reset", 1'h1, read_ready)
        `CHK("valid_in_reset", 1'h0, sov)
        `CHK("data_in_reset", 1'h0, sdo)
    endtask

    task automatic test_open(input logic [47:0] v);
        @(posedge clk);
        open_flags <= v;
        short_flags <= ~v[15:0];
        llf_host_model_inst.read_word(1'h0, 1, w, n);
        `CHK("open_word", v, w)
        `CHK("open_count", 48, n)
    endtask

    task automatic test_short(input logic [15:0] v);
        @(posedge clk);
        open_flags <= 48'hFFFFFFFFFFFF;
        short_flags <= v;
        llf_host_model_inst.read_word(1'h1, 1, w, n);
        `CHK("short_word", {32'h0, v}, w)
        `CHK("short_count", 48, n)
    endtask

    // Back-to-back reads, then a cleared warning must read zero.
    task automatic test_back();
        @(posedge clk);
        open_flags <= 48'h123456789ABC;
        short_flags <= 16'hDEF0;
        llf_host_model_inst.read_word(1'h0, 1, w, n);
        `CHK("b2b_open", 48'h123456789ABC, w)
        llf_host_model_inst.read_word(1'h1, 0, w, n);
        `CHK("b2b_short", 48'h00000000DEF0, w)
        @(posedge clk);
        open_flags <= 48'h0;
        short_flags <= 16'h0;
        llf_host_model_inst.read_word(1'h0, 1, w, n);
        `CHK("cleared_open", 48'h0, w)
        llf_host_model_inst.read_word(1'h1, 0, w, n);
        `CHK("cleared_short", 48'h0, w)
    endtask

    // Inputs change while the clock enable is low, then are read.
    task automatic test_freeze();
        @(posedge clk);
        clk_en <= 1'h0;
        open_flags <= 48'hA5A5A5A5A5A5;
        short_flags <= 16'h5A5A;
        repeat (4) @(posedge clk);
        clk_en <= 1'h1;
        llf_host_model_inst.read_word(1'h0, 1, w, n);
        `CHK("freeze_open", 48'hA5A5A5A5A5A5, w)
        llf_host_model_inst.read_word(1'h1, 0, w, n);
        `CHK("freeze_short", 48'h000000005A5A, w)
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        test_reset();
        @(posedge clk);
        rst <= 1'h0;
        test_open(48'h800000000001);
        test_open(48'h7FFFFFFFFFFE);
        test_short(16'h8000);
        test_short(16'h0001);
        test_short(16'hFFFF);
        test_back();
        test_freeze();
        test_done();
    end

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule
